//--- rtl/emb_bus.sv
`timescale 1ns/100ps
// Summary of operation
// - The read strobe is active for the single strobe-phase cycle of every external read access.
// - With full-width strobe mode the write strobe is active on every external write.
// - With low-byte mode the pin strobes only low-byte writes on a 16-bit bus and all on 8-bit.
// - A configuration bit in the setup register selects full-width or low-byte strobe mode.
// - In multiplexed modes an address latch pulse is driven for external latches to use.
// - A low fetch-select pin at and after reset makes code fetches go to external memory.
// - A high fetch-select pin makes code execute from internal program memory.
// - Demultiplexed mode puts only data on the muxed port, high half only on a 16-bit path.
// - Multiplexed mode puts the address and then the data on the muxed port lines.
// - Demultiplexed mode drives the full 16-bit address on the address port.
// - After a switch to multiplexed mode the address port keeps driving the address.
// - Each pin group is two byte ports with a per-pin direction bit when not used by the bus.
// - A pin set as input has its output driver off.
// - A separate pin is high byte enable in full-width mode and high byte strobe otherwise.
module emb_bus
	import emb_pkg::*;
(
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [11:0] s_awaddr_i,
	input wire logic s_awvalid_i,
	output logic s_awready_o,
	input wire logic [31:0] s_wdata_i,
	input wire logic [3:0] s_wstrb_i,
	input wire logic s_wvalid_i,
	output logic s_wready_o,
	output logic [1:0] s_bresp_o,
	output logic s_bvalid_o,
	input wire logic s_bready_i,
	input wire logic [11:0] s_araddr_i,
	input wire logic s_arvalid_i,
	output logic s_arready_o,
	output logic [31:0] s_rdata_o,
	output logic [1:0] s_rresp_o,
	output logic s_rvalid_o,
	input wire logic s_rready_i,
	input wire emb_req_s req_i,
	input wire logic req_fetch_i,
	input wire logic req_valid_i,
	output logic req_ready_o,
	output logic [EMB_DW-1:0] rsp_data_o,
	output logic rsp_valid_o,
	input wire logic rsp_ready_i,
	input wire logic external_fetch_select_n_i,
	output logic fetch_external_o,
	output logic read_strobe_n_o,
	output logic low_byte_store_pulse_n_o,
	output logic upper_byte_enable_n_o,
	output logic address_latch_o,
	input wire logic [EMB_DW-1:0] muxed_data_port_i,
	output logic [EMB_DW-1:0] muxed_data_port_o,
	output logic [EMB_DW-1:0] muxed_data_port_oe_o,
	input wire logic [EMB_AW-1:0] address_port_i,
	output logic [EMB_AW-1:0] address_port_o,
	output logic [EMB_AW-1:0] address_port_oe_o
);
	logic [1:0] sel_sync;
	logic [EMB_DW-1:0] mux_s1, mux_s2, adr_s1, adr_s2;
	logic fetch_ext, strap_pending, next_fetch_ext, next_strap_pending;
	emb_cfg_s cfg, next_cfg;
	logic was_demux, next_was_demux;
	logic [EMB_DW-1:0] mux_dir, next_mux_dir, mux_out, next_mux_out;
	logic [EMB_AW-1:0] adr_dir, next_adr_dir, adr_out, next_adr_out;
	logic aw_got, w_got, next_aw_got, next_w_got, bvalid, next_bvalid;
	logic [11:0] aw_addr, next_aw_addr;
	logic [31:0] w_data, next_w_data, rdata, next_rdata;
	logic [1:0] bresp, next_bresp, rresp, next_rresp;
	logic rvalid, next_rvalid;
	emb_state_e st, next_st;
	emb_req_s cur, next_cur;
	logic [EMB_DW-1:0] last_rd, next_last_rd;
	logic [EMB_DW-1:0] buf0, buf1, next_buf0, next_buf1;
	logic [1:0] cnt, next_cnt;
	logic push, pop;
	logic [1:0] lag, next_lag;
	logic [EMB_DW-1:0] rd_word;

	function automatic logic [31:0] reg_read(input logic [11:0] a);
		reg_read = 32'h0;
		unique case (a)
			EMB_SETUP_OFS: reg_read = {28'h0, cfg};
			EMB_MUXDIR_OFS: reg_read = {16'h0, mux_dir};
			EMB_MUXOUT_OFS: reg_read = {16'h0, mux_out};
			EMB_ADRDIR_OFS: reg_read = {16'h0, adr_dir};
			EMB_ADROUT_OFS: reg_read = {16'h0, adr_out};
			EMB_STATUS_OFS: reg_read = {30'h0, fetch_ext, st == EMB_IDLE};
			EMB_RDDATA_OFS: reg_read = {16'h0, last_rd};
			default: reg_read = 32'h0;
		endcase
	endfunction : reg_read

	function automatic logic mapped(input logic [11:0] a);
		mapped = (a <= EMB_RDDATA_OFS) && (a[1:0] == 2'h0);
	endfunction : mapped

	// Pin inputs pass two flops before any logic reads them.
	always_ff @(posedge clk_i) begin
		sel_sync <= {sel_sync[0], external_fetch_select_n_i};
		mux_s1 <= muxed_data_port_i;
		mux_s2 <= mux_s1;
		adr_s1 <= address_port_i;
		adr_s2 <= adr_s1;
	end

	// The fetch-select level is caught on the first clocked cycle after reset release.
	always_comb begin
		next_fetch_ext = fetch_ext;
		next_strap_pending = 1'b0;
		if (strap_pending) begin
			next_fetch_ext = ~sel_sync[1];
		end
	end
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			fetch_ext <= 1'b0;
			strap_pending <= 1'b1;
		end else begin
			fetch_ext <= next_fetch_ext;
			strap_pending <= next_strap_pending;
		end
	end
	assign fetch_external_o = fetch_ext;

	assign s_awready_o = ~aw_got & ~bvalid;
	assign s_wready_o = ~w_got & ~bvalid;
	assign s_arready_o = ~rvalid;
	always_comb begin
		next_aw_got = aw_got;
		next_w_got = w_got;
		next_aw_addr = aw_addr;
		next_w_data = w_data;
		next_bvalid = bvalid;
		next_bresp = bresp;
		next_rvalid = rvalid;
		next_rdata = rdata;
		next_rresp = rresp;
		next_cfg = cfg;
		next_mux_dir = mux_dir;
		next_mux_out = mux_out;
		next_adr_dir = adr_dir;
		next_adr_out = adr_out;
		next_was_demux = was_demux;
		if (s_awvalid_i && s_awready_o) begin
			next_aw_got = 1'b1;
			next_aw_addr = s_awaddr_i;
		end
		if (s_wvalid_i && s_wready_o) begin
			next_w_got = 1'b1;
			next_w_data = s_wdata_i;
		end
		if (aw_got && w_got) begin
			next_aw_got = 1'b0;
			next_w_got = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = mapped(aw_addr) ? EMB_RESP_OK : EMB_RESP_ERR;
			unique case (aw_addr)
				EMB_SETUP_OFS: begin
					next_cfg = emb_cfg_s'(w_data[3:0]);
					if (!w_data[EMB_CFG_MUX]) begin
						next_was_demux = w_data[EMB_CFG_BUS];
					end
				end
				EMB_MUXDIR_OFS: next_mux_dir = w_data[15:0];
				EMB_MUXOUT_OFS: next_mux_out = w_data[15:0];
				EMB_ADRDIR_OFS: next_adr_dir = w_data[15:0];
				EMB_ADROUT_OFS: next_adr_out = w_data[15:0];
				default: next_bresp = mapped(aw_addr) ? EMB_RESP_OK : EMB_RESP_ERR;
			endcase
		end
		if (bvalid && s_bready_i) begin
			next_bvalid = 1'b0;
		end
		if (s_arvalid_i && s_arready_o) begin
			next_rvalid = 1'b1;
			next_rdata = reg_read(s_araddr_i);
			next_rresp = mapped(s_araddr_i) ? EMB_RESP_OK : EMB_RESP_ERR;
		end else if (rvalid && s_rready_i) begin
			next_rvalid = 1'b0;
		end
	end
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			aw_got <= 1'b0;
			w_got <= 1'b0;
			aw_addr <= 12'h0;
			w_data <= 32'h0;
			bvalid <= 1'b0;
			bresp <= EMB_RESP_OK;
			rvalid <= 1'b0;
			rdata <= 32'h0;
			rresp <= EMB_RESP_OK;
			cfg <= emb_cfg_s'(EMB_SETUP_RST);
			mux_dir <= 16'h0;
			mux_out <= 16'h0;
			adr_dir <= 16'h0;
			adr_out <= 16'h0;
			was_demux <= 1'b0;
		end else begin
			aw_got <= next_aw_got;
			w_got <= next_w_got;
			aw_addr <= next_aw_addr;
			w_data <= next_w_data;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			rvalid <= next_rvalid;
			rdata <= next_rdata;
			rresp <= next_rresp;
			cfg <= next_cfg;
			mux_dir <= next_mux_dir;
			mux_out <= next_mux_out;
			adr_dir <= next_adr_dir;
			adr_out <= next_adr_out;
			was_demux <= next_was_demux;
		end
	end
	assign s_bvalid_o = bvalid;
	assign s_bresp_o = bresp;
	assign s_rvalid_o = rvalid;
	assign s_rdata_o = rdata;
	assign s_rresp_o = rresp;

	// Access sequencer: address phase, latch hold, strobe phase, completion.
	assign req_ready_o = (st == EMB_IDLE) && cfg.bus_on && (cnt < 2'h2);
	assign push = (st == EMB_DONE) && !cur.write && (lag == EMB_RD_LAG);
	assign rd_word = cfg.wide ? mux_s2 : {8'h0, mux_s2[7:0]};
	always_comb begin
		next_st = st;
		next_cur = cur;
		next_last_rd = last_rd;
		next_lag = lag;
		unique case (st)
			EMB_IDLE: begin
				if (req_valid_i && req_ready_o) begin
					next_cur = req_i;
					next_cur.write = req_i.write & ~req_fetch_i;
					next_st = cfg.multiplexed ? EMB_ADDR : EMB_DATA;
				end
			end
			EMB_ADDR: next_st = EMB_HOLD;
			EMB_HOLD: next_st = EMB_DATA;
			EMB_DATA: begin
				next_st = EMB_DONE;
				next_lag = 2'h0;
			end
			EMB_DONE: begin
				// A read waits until the strobe-cycle pin data leaves the second flop.
				if (cur.write || (lag == EMB_RD_LAG)) begin
					next_st = EMB_IDLE;
				end else begin
					next_lag = 2'(lag + 2'h1);
				end
				if (push) begin
					next_last_rd = rd_word;
				end
			end
		endcase
	end
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			st <= EMB_IDLE;
			cur <= '0;
			last_rd <= 16'h0;
			lag <= 2'h0;
		end else begin
			st <= next_st;
			cur <= next_cur;
			last_rd <= next_last_rd;
			lag <= next_lag;
		end
	end

	// Two-entry read data buffer; the sequencer stalls while it holds two words.
	assign pop = rsp_valid_o && rsp_ready_i;
	always_comb begin
		next_buf0 = buf0;
		next_buf1 = buf1;
		next_cnt = cnt;
		if (pop) begin
			next_buf0 = buf1;
			next_cnt = 2'(cnt - 2'h1);
		end
		if (push) begin
			if (next_cnt == 2'h0) next_buf0 = rd_word;
			else next_buf1 = rd_word;
			next_cnt = 2'(next_cnt + 2'h1);
		end
	end
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			buf0 <= 16'h0;
			buf1 <= 16'h0;
			cnt <= 2'h0;
		end else begin
			buf0 <= next_buf0;
			buf1 <= next_buf1;
			cnt <= next_cnt;
		end
	end
	assign rsp_valid_o = cnt != 2'h0;
	assign rsp_data_o = buf0;

	// Pin drive, registered from the sequencer state.
	logic in_acc, data_ph, addr_ph;
	assign in_acc = (st != EMB_IDLE) && (st != EMB_DONE);
	assign addr_ph = (st == EMB_ADDR) || (st == EMB_HOLD);
	assign data_ph = st == EMB_DATA;
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			read_strobe_n_o <= 1'b1;
			low_byte_store_pulse_n_o <= 1'b1;
			upper_byte_enable_n_o <= 1'b1;
			address_latch_o <= 1'b0;
			muxed_data_port_o <= 16'h0;
			muxed_data_port_oe_o <= 16'h0;
			address_port_o <= 16'h0;
			address_port_oe_o <= 16'h0;
		end else begin
			read_strobe_n_o <= ~(data_ph & ~cur.write);
			address_latch_o <= cfg.multiplexed && (st == EMB_ADDR);
			if (!cfg.store_low) begin
				low_byte_store_pulse_n_o <= ~(data_ph & cur.write);
				upper_byte_enable_n_o <= ~(in_acc & cfg.wide & cur.be[1]);
			end else begin
				low_byte_store_pulse_n_o <= ~(data_ph & cur.write &
					(cur.be[0] | ~cfg.wide));
				upper_byte_enable_n_o <= ~(data_ph & cur.write & cfg.wide & cur.be[1]);
			end
			if (in_acc && addr_ph) begin
				muxed_data_port_o <= cur.addr;
				muxed_data_port_oe_o <= 16'hffff;
			end else if (in_acc && cur.write) begin
				muxed_data_port_o <= cfg.wide ? cur.wdata : {mux_out[15:8], cur.wdata[7:0]};
				muxed_data_port_oe_o <= cfg.wide ? 16'hffff : {mux_dir[15:8], 8'hff};
			end else if (in_acc || (cfg.bus_on && cfg.wide)) begin
				muxed_data_port_o <= mux_out;
				muxed_data_port_oe_o <= cfg.wide ? 16'h0 : {mux_dir[15:8], 8'h0};
			end else begin
				muxed_data_port_o <= mux_out;
				muxed_data_port_oe_o <= cfg.bus_on ? {mux_dir[15:8], 8'h0} : mux_dir;
			end
			if (cfg.bus_on && (!cfg.multiplexed || was_demux)) begin
				address_port_o <= cur.addr;
				address_port_oe_o <= 16'hffff;
			end else begin
				address_port_o <= adr_out;
				address_port_oe_o <= adr_dir;
			end
		end
	end

	strobe_read_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(st == EMB_DATA && !cur.write) |=> !read_strobe_n_o)
		else $error("read strobe missing");
	strobe_full_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(st == EMB_DATA && cur.write && !cfg.store_low && $stable(cfg))
		|=> !low_byte_store_pulse_n_o)
		else $error("write strobe missing");
	strobe_lowonly_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(st == EMB_DATA && cfg.store_low && cfg.wide && !cur.be[0] && $stable(cfg))
		|=> low_byte_store_pulse_n_o)
		else $error("low strobe on high write");
	cfg_write_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(aw_got && w_got && aw_addr == EMB_SETUP_OFS)
		|=> cfg.store_low == $past(w_data[EMB_CFG_STORE]))
		else $error("setup not stored");
	latch_pulse_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(st == EMB_ADDR && cfg.multiplexed && $stable(cfg))
		|=> address_latch_o ##1 !address_latch_o)
		else $error("latch pulse wrong");
	fetch_strap_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		strap_pending |=> fetch_ext == !$past(sel_sync[1]))
		else $error("fetch select wrong");
	mux_addr_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(st == EMB_ADDR) |=> muxed_data_port_o == cur.addr)
		else $error("address not on muxed port");
	addr_drive_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(cfg.bus_on && !cfg.multiplexed && $stable(cfg)) |=> address_port_oe_o == 16'hffff)
		else $error("address port not driven");
	hbe_full_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(st == EMB_IDLE && !cfg.store_low && $stable(cfg)) |=> upper_byte_enable_n_o)
		else $error("byte enable outside access");
	buf_cap_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		cnt <= 2'h2)
		else $error("buffer overflow");
	read_mux_c: cover property (@(posedge clk_i) disable iff (sys_rst_i)
		st == EMB_ADDR ##2 (st == EMB_DATA && !cur.write));
	write_low_c: cover property (@(posedge clk_i) disable iff (sys_rst_i)
		st == EMB_DATA && cur.write && cfg.store_low);
	buf_full_c: cover property (@(posedge clk_i) disable iff (sys_rst_i) cnt == 2'h2);
endmodule : emb_bus

//--- rtl/emb_pkg.sv
package emb_pkg;
	localparam int EMB_AW = 16;
	localparam int EMB_DW = 16;
	localparam int EMB_BYTE = 8;
	// Byte addresses of the register words.
	localparam logic [11:0] EMB_SETUP_OFS = 12'h000;
	localparam logic [11:0] EMB_MUXDIR_OFS = 12'h004;
	localparam logic [11:0] EMB_MUXOUT_OFS = 12'h008;
	localparam logic [11:0] EMB_ADRDIR_OFS = 12'h00c;
	localparam logic [11:0] EMB_ADROUT_OFS = 12'h010;
	localparam logic [11:0] EMB_STATUS_OFS = 12'h014;
	localparam logic [11:0] EMB_RDDATA_OFS = 12'h018;
	// Setup register field positions.
	localparam int EMB_CFG_STORE = 0;
	localparam int EMB_CFG_MUX = 1;
	localparam int EMB_CFG_WIDE = 2;
	localparam int EMB_CFG_BUS = 3;
	localparam logic [3:0] EMB_SETUP_RST = 4'h0;
	localparam logic [1:0] EMB_RESP_OK = 2'h0;
	localparam logic [1:0] EMB_RESP_ERR = 2'h2;
	// Cycles a read waits after its strobe until the pin data has crossed the input synchroniser.
	localparam logic [1:0] EMB_RD_LAG = 2'h2;

	typedef struct packed {
		logic write;
		logic [1:0] be;
		logic [EMB_AW-1:0] addr;
		logic [EMB_DW-1:0] wdata;
	} emb_req_s;

	// Members run from bit 3 down to bit 0, matching the setup register field positions.
	typedef struct packed {
		logic bus_on;
		logic wide;
		logic multiplexed;
		logic store_low;
	} emb_cfg_s;

	typedef enum logic [4:0] {
		EMB_IDLE = 5'h01,
		EMB_ADDR = 5'h02,
		EMB_HOLD = 5'h04,
		EMB_DATA = 5'h08,
		EMB_DONE = 5'h10
	} emb_state_e;
endpackage : emb_pkg

//--- tb/emb_mem_model.sv
`timescale 1ns/100ps
// External memory behind the bus pins, with an address latch for multiplexed modes.
module emb_mem_model
	import emb_pkg::*;
(
	input wire logic clk_i,
	input wire logic mux_i,
	input wire logic address_latch_i,
	input wire logic [EMB_DW-1:0] muxed_oe_i,
	input wire logic [EMB_DW-1:0] muxed_out_i,
	input wire logic [EMB_AW-1:0] address_i,
	output logic [EMB_DW-1:0] wire_o
);
	logic [EMB_AW-1:0] latched = '0;
	logic [EMB_AW-1:0] addr;
	logic [EMB_DW-1:0] word;
	// The latch pulse captures the address from the muxed lines.
	always_ff @(posedge clk_i) begin
		if (address_latch_i) begin
			latched <= muxed_out_i;
		end
	end
	assign addr = mux_i ? latched : address_i;
	assign word = {addr[7:0] ^ 8'h3c, ~addr[7:0]};
	// Memory drives only the lines that the device has released.
	assign wire_o = (muxed_out_i & muxed_oe_i) | (word & ~muxed_oe_i);
endmodule : emb_mem_model

//--- tb/tb_emb_bus.sv
`timescale 1ns/100ps
module tb_emb_bus
	import emb_pkg::*;
;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [11:0] awaddr = '0;
	logic [11:0] araddr = '0;
	logic [31:0] wdata = '0;
	logic [31:0] rdata;
	logic [1:0] bresp;
	logic [1:0] rresp;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid;
	emb_req_s req = '0;
	logic fetch = 0, req_valid = 0, rsp_ready = 1, sel_n = 0, mux = 0;
	logic req_ready, rsp_valid, fext, rd_n, st_n, ub_n, latch;
	logic [15:0] rsp_data, mp_i, mp_o, mp_oe, ap_i, ap_o, ap_oe, rd_a, st_d, al_a, rsp_d;
	int fail_count = 0, check_count = 0, n_rd, n_st, n_ub, n_al, n_rsp;
	assign ap_i = (ap_o & ap_oe) | (~ap_o & ~ap_oe);
	emb_bus emb_bus_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .s_awaddr_i(awaddr),
		.s_awvalid_i(awvalid), .s_awready_o(awready), .s_wdata_i(wdata), .s_wstrb_i(4'hf),
		.s_wvalid_i(wvalid), .s_wready_o(wready), .s_bresp_o(bresp), .s_bvalid_o(bvalid),
		.s_bready_i(bready), .s_araddr_i(araddr), .s_arvalid_i(arvalid), .s_arready_o(arready),
		.s_rdata_o(rdata), .s_rresp_o(rresp), .s_rvalid_o(rvalid), .s_rready_i(rready),
		.req_i(req), .req_fetch_i(fetch), .req_valid_i(req_valid), .req_ready_o(req_ready),
		.rsp_data_o(rsp_data), .rsp_valid_o(rsp_valid), .rsp_ready_i(rsp_ready),
		.external_fetch_select_n_i(sel_n), .fetch_external_o(fext), .read_strobe_n_o(rd_n),
		.low_byte_store_pulse_n_o(st_n), .upper_byte_enable_n_o(ub_n),
		.address_latch_o(latch), .muxed_data_port_i(mp_i), .muxed_data_port_o(mp_o),
		.muxed_data_port_oe_o(mp_oe), .address_port_i(ap_i), .address_port_o(ap_o),
		.address_port_oe_o(ap_oe));
	emb_mem_model emb_mem_model_inst (.clk_i(clk_i), .mux_i(mux), .address_latch_i(latch),
		.muxed_oe_i(mp_oe), .muxed_out_i(mp_o), .address_i(ap_o), .wire_o(mp_i));
	always #4 clk_i = ~clk_i;
	// Pins are sampled mid-cycle, where every registered output has settled.
	always @(negedge clk_i) begin
		if (!rd_n) begin
			n_rd++;
			rd_a = ap_o;
		end
		if (!st_n) begin
			n_st++;
			st_d = mp_o;
		end
		if (!ub_n) n_ub++;
		if (latch) begin
			n_al++;
			al_a = mp_o;
		end
		if (rsp_valid && rsp_ready) begin
			n_rsp++;
			rsp_d = rsp_data;
		end
	end
	function automatic logic [15:0] memv(input logic [15:0] a);
		return {a[7:0] ^ 8'h3c, ~a[7:0]};
	endfunction : memv
	task automatic ck(input logic ok, input string m);
		check_count++;
		if (ok !== 1'b1) begin
			fail_count++;
			$display("BAD %0t %s", $time, m);
		end
	endtask : ck
	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : finish_test
	task automatic reset_dut();
		sys_rst_i <= 1'b1;
		repeat (20) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		repeat (4) @(posedge clk_i);
	endtask : reset_dut
	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
		logic ta, tw, tk;
		int n;
		n = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge clk_i);
			ta = awvalid & awready;
			tw = wvalid & wready;
			tk = bvalid;
			n++;
			@(posedge clk_i);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end while (!tk && n < 50);
		bready <= 1'b0;
		ck(tk, "no write response");
		@(posedge clk_i);
	endtask : axi_wr
	task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ta, tk;
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge clk_i);
			ta = arvalid & arready;
			tk = rvalid;
			d = rdata;
			r = rresp;
			n++;
			@(posedge clk_i);
			if (ta) arvalid <= 1'b0;
		end while (!tk && n < 50);
		rready <= 1'b0;
		ck(tk, "no read response");
		@(posedge clk_i);
	endtask : axi_rd
	task automatic access(input logic w, input logic [1:0] be, input logic [15:0] a,
		input logic [15:0] d);
		logic t;
		int n;
		n = 0;
		n_rd = 0;
		n_st = 0;
		n_ub = 0;
		n_al = 0;
		req <= '{write: w, be: be, addr: a, wdata: d};
		req_valid <= 1'b1;
		do begin
			@(negedge clk_i);
			t = req_ready;
			n++;
			@(posedge clk_i);
		end while (!t && n < 100);
		req_valid <= 1'b0;
		ck(t, "request not taken");
		repeat (8) @(posedge clk_i);
	endtask : access
	initial begin
		repeat (20000) @(posedge clk_i);
		fail_count++;
		finish_test();
	end
	initial begin
		logic [31:0] d;
		logic [1:0] r, be;
		logic [15:0] a, wd;
		logic ex;
		void'($urandom(32'h862c));
		reset_dut();
		ck(fext === 1'b1, "external fetch not chosen");
		axi_wr(EMB_MUXDIR_OFS, 32'h00a5);
		axi_wr(EMB_MUXOUT_OFS, 32'h0f0f);
		ck(mp_oe === 16'h00a5, "port direction");
		ck((mp_o & mp_oe) === 16'h0005, "port output");
		axi_rd(12'h0fc, d, r);
		ck(r === EMB_RESP_ERR, "unmapped read accepted");
		for (int c = 0; c < 8; c++) begin
			axi_wr(EMB_SETUP_OFS, {28'h0, 1'b1, 3'(c)});
			axi_rd(EMB_SETUP_OFS, d, r);
			ck(d === {28'h0, 1'b1, 3'(c)} && r === EMB_RESP_OK, "setup readback");
			mux <= c[1];
			a = 16'($urandom);
			wd = 16'($urandom);
			be = 2'($urandom_range(3, 1));
			if (c == 7) be = 2'h2;
			access(1'b1, be, a, wd);
			ex = !c[0] || !c[2] || be[0];
			ck(n_st === int'(ex), "store pulse count");
			ck((n_ub != 0) === (c[2] && be[1]), "upper byte pin");
			ck(n_al === int'(c[1]), "latch pulse count");
			if (ex) ck(st_d[7:0] === wd[7:0], "low data");
			if (ex && c[2]) ck(st_d[15:8] === wd[15:8], "high data");
			if (c[1]) ck(al_a[7:0] === a[7:0], "address on muxed port");
			a = 16'($urandom);
			access(1'b0, 2'h3, a, 16'h0);
			ck(n_rd === 1 && n_st === 0, "read strobe");
			ck(rd_a === a && ap_oe === 16'hffff, "address port");
			ck(rsp_d[7:0] === 8'(memv(a)), "read data");
		end
		fetch <= 1'b1;
		access(1'b1, 2'h3, 16'h1234, 16'hffff);
		fetch <= 1'b0;
		ck(n_rd === 1 && n_st === 0, "fetch strobes");
		rsp_ready <= 1'b0;
		n_rsp = 0;
		access(1'b0, 2'h3, 16'h0011, 16'h0);
		access(1'b0, 2'h3, 16'h0022, 16'h0);
		@(negedge clk_i);
		ck(req_ready === 1'b0, "full buffer accepts");
		@(posedge clk_i);
		rsp_ready <= 1'b1;
		repeat (6) @(posedge clk_i);
		ck(n_rsp === 2 && rsp_d === memv(16'h0022), "buffer drain");
		sel_n <= 1'b1;
		reset_dut();
		ck(fext === 1'b0, "internal fetch not chosen");
		finish_test();
	end
endmodule : tb_emb_bus
